//--- hw/cdr_pkg.sv
// ----------------------------------------------------------------------------
// constants and types for the phase detection core
// ----------------------------------------------------------------------------
package cdr_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOCK_WINDOW_NS = 40;
  // longest tolerated pulse, rounded down, never below one cycle
  localparam int LOCK_WINDOW_CYC = (LOCK_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                   (LOCK_WINDOW_NS / CLK_PERIOD_NS);
  localparam logic [3:0] PULSE_MAX = 4'hF;
  localparam logic [4:0] LOCK_COUNT = 5'h10;

  // delay line geometry
  localparam int TAPS = 8;
  localparam int CENTER_TAP = 4;
  localparam logic [3:0] CENTER_EDGE = 4'h3;
  localparam int ERR_W = 4;

  // reset values
  localparam logic [TAPS-1:0] CHAIN_RST = 8'h00;
  localparam logic [ERR_W-1:0] ERR_RST = 4'h0;
  localparam logic [4:0] LOCK_RST = 5'h00;
  localparam logic [3:0] PULSE_RST = 4'h0;

  // three-state detector states; CLEAR is the one-cycle both-high state
  typedef enum logic [1:0] {
    PFD_IDLE,
    PFD_BEHIND,
    PFD_AHEAD,
    PFD_CLEAR
  } pfd_state_t;

endpackage

//--- hw/cdr_phase_detector.sv
// Summary of operation
// R1 - detector leaves reset idle with both steering outputs low
// R2 - reference rising edge in idle raises osc_behind, entering lag state
// R3 - oscillator edge while behind raises both briefly, then both clear to idle
// R4 - only rising edges of either clock move the detector
// R5 - osc_behind when oscillator slower, osc_ahead when faster or leading
// R6 - serial data runs through a tapped chain, every tap sampled by oscillator
// R7 - chain delay exceeds one oscillator period, not beyond two
// R8 - each sampled tap passes two oscillator-timed register stages before use
// R9 - steering drives data transitions toward the middle tap
// R10 - neighbouring taps compared; all equal means no transition this period
// R11 - update enable from comparisons; phase error otherwise holds
// R12 - more than one transition in a sample period is flagged
// R13 - up to two transitions handled, exactly one selected
// R14 - with two, choose by last phase or oscillator frequency direction
// R15 - source sends coded data, at most five bit times without transition
// R16 - data-based recovery starts only after lock to reference
// R17 - source data is single rate, one level change per bit at most
// R18 - retimed serial data provided alongside phase error
// R19 - phase error is signed tap distance of chosen transition from centre
// R20 - retimed bit taken from centre tap on opposite oscillator edge
// R21 - both-high clear lasts one cycle, idle then ready for next edge
`timescale 1ns/1ps

module cdr_phase_detector (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // reference and oscillator clocks, sampled as levels
  input wire logic ref_osc_in,
  input wire logic controlled_osc_clock,
  // coded serial data
  input wire logic serial_in,
  // frequency steering
  output logic osc_behind,
  output logic osc_ahead,
  output logic locked,
  // data side results
  output logic signed [cdr_pkg::ERR_W-1:0] phase_error,
  output logic err_update,
  output logic multi_trans,
  output logic retimed_data
);

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------

  // number of transitions among neighbouring taps
  function automatic logic [2:0] count_edges(input logic [cdr_pkg::TAPS-2:0] e);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < cdr_pkg::TAPS - 1; i++) begin
      n = n + {2'h0, e[i]};
    end
    return n;
  endfunction

  // lowest transition index
  function automatic logic [2:0] first_edge(input logic [cdr_pkg::TAPS-2:0] e);
    logic [2:0] p;
    p = 3'h0;
    for (int i = cdr_pkg::TAPS - 2; i >= 0; i--) begin
      if (e[i]) begin
        p = 3'(i);
      end
    end
    return p;
  endfunction

  // highest transition index
  function automatic logic [2:0] last_edge(input logic [cdr_pkg::TAPS-2:0] e);
    logic [2:0] p;
    p = 3'h0;
    for (int i = 0; i < cdr_pkg::TAPS - 1; i++) begin
      if (e[i]) begin
        p = 3'(i);
      end
    end
    return p;
  endfunction

  // --------------------------------------------------------------------------
  // edge detection and three-state detector
  // --------------------------------------------------------------------------
  logic ref_d, osc_d, ref_rise, osc_rise, osc_fall;
  logic freq_fast, next_freq_fast;
  logic next_behind, next_ahead;
  cdr_pkg::pfd_state_t pfd_state, next_pfd_state;

  // level is ignored, only the low-to-high step counts
  assign ref_rise = ref_osc_in & ~ref_d; // R4
  assign osc_rise = controlled_osc_clock & ~osc_d; // R4
  assign osc_fall = ~controlled_osc_clock & osc_d;

  // next state; simultaneous edges in idle cancel out
  always_comb begin
    next_pfd_state = pfd_state;
    next_freq_fast = freq_fast;
    case (pfd_state)
      cdr_pkg::PFD_IDLE: begin
        if (ref_rise && !osc_rise) begin
          next_pfd_state = cdr_pkg::PFD_BEHIND; // R2
          next_freq_fast = 1'b0;
        end else if (osc_rise && !ref_rise) begin
          next_pfd_state = cdr_pkg::PFD_AHEAD; // R5
          next_freq_fast = 1'b1;
        end
      end
      cdr_pkg::PFD_BEHIND: begin
        if (osc_rise) begin
          next_pfd_state = cdr_pkg::PFD_CLEAR; // R3
        end
      end
      cdr_pkg::PFD_AHEAD: begin
        if (ref_rise) begin
          next_pfd_state = cdr_pkg::PFD_CLEAR; // R3
        end
      end
      cdr_pkg::PFD_CLEAR: begin
        // edges here are lost; one cycle is the price of a clocked reset
        next_pfd_state = cdr_pkg::PFD_IDLE; // R21
      end
      default: begin
        next_pfd_state = cdr_pkg::PFD_IDLE;
      end
    endcase
    next_behind = (next_pfd_state == cdr_pkg::PFD_BEHIND) ||
                  (next_pfd_state == cdr_pkg::PFD_CLEAR); // R5
    next_ahead = (next_pfd_state == cdr_pkg::PFD_AHEAD) ||
                 (next_pfd_state == cdr_pkg::PFD_CLEAR); // R5
  end

  // registered detector outputs, idle after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_d <= 1'b0;
      osc_d <= 1'b0;
      pfd_state <= cdr_pkg::PFD_IDLE; // R1
      osc_behind <= 1'b0; // R1
      osc_ahead <= 1'b0; // R1
      freq_fast <= 1'b0;
    end else begin
      ref_d <= ref_osc_in;
      osc_d <= controlled_osc_clock;
      pfd_state <= next_pfd_state;
      osc_behind <= next_behind;
      osc_ahead <= next_ahead;
      freq_fast <= next_freq_fast;
    end
  end

  // --------------------------------------------------------------------------
  // lock detection
  // --------------------------------------------------------------------------
  logic [3:0] pulse_len, next_pulse_len;
  logic [4:0] lock_cnt, next_lock_cnt;
  logic next_locked;

  // a comparison is tight when its steering pulse stayed short
  always_comb begin
    next_pulse_len = pulse_len;
    next_lock_cnt = lock_cnt;
    if (pfd_state == cdr_pkg::PFD_BEHIND || pfd_state == cdr_pkg::PFD_AHEAD) begin
      if (pulse_len != cdr_pkg::PULSE_MAX) begin
        next_pulse_len = pulse_len + 4'h1;
      end
    end else begin
      next_pulse_len = cdr_pkg::PULSE_RST;
    end
    if (next_pfd_state == cdr_pkg::PFD_CLEAR) begin
      if (pulse_len <= 4'(cdr_pkg::LOCK_WINDOW_CYC)) begin
        if (lock_cnt != cdr_pkg::LOCK_COUNT) begin
          next_lock_cnt = lock_cnt + 5'h01;
        end
      end else begin
        next_lock_cnt = cdr_pkg::LOCK_RST;
      end
    end
    next_locked = (next_lock_cnt == cdr_pkg::LOCK_COUNT); // R16
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_len <= cdr_pkg::PULSE_RST;
      lock_cnt <= cdr_pkg::LOCK_RST;
      locked <= 1'b0;
    end else begin
      pulse_len <= next_pulse_len;
      lock_cnt <= next_lock_cnt;
      locked <= next_locked;
    end
  end

  // --------------------------------------------------------------------------
  // tapped delay line and sampling
  // --------------------------------------------------------------------------
  logic [cdr_pkg::TAPS-1:0] chain, next_chain;
  logic [cdr_pkg::TAPS-1:0] samp1, next_samp1, samp2, next_samp2;
  logic samp_new, next_retimed;

  // chain length must span one to two oscillator periods of core cycles
  always_comb begin
    next_chain = {chain[cdr_pkg::TAPS-2:0], serial_in}; // R6 R7
    next_samp1 = samp1;
    next_samp2 = samp2;
    next_retimed = retimed_data;
    if (osc_rise) begin
      next_samp1 = chain; // R6
      next_samp2 = samp1; // R8
    end
    if (osc_fall) begin
      next_retimed = chain[cdr_pkg::CENTER_TAP]; // R18 R20
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chain <= cdr_pkg::CHAIN_RST;
      samp1 <= cdr_pkg::CHAIN_RST;
      samp2 <= cdr_pkg::CHAIN_RST;
      samp_new <= 1'b0;
      retimed_data <= 1'b0;
    end else begin
      chain <= next_chain;
      samp1 <= next_samp1;
      samp2 <= next_samp2;
      samp_new <= osc_rise;
      retimed_data <= next_retimed;
    end
  end

  // --------------------------------------------------------------------------
  // transition filter and phase error
  // --------------------------------------------------------------------------
  logic [cdr_pkg::TAPS-2:0] edges;
  logic [2:0] n_edges, pick;
  logic signed [cdr_pkg::ERR_W-1:0] next_phase_error;
  logic next_err_update, next_multi;

  // neighbour comparison; all equal taps give no transition
  assign edges = samp2[cdr_pkg::TAPS-2:0] ^ samp2[cdr_pkg::TAPS-1:1]; // R10
  assign n_edges = count_edges(edges);

  always_comb begin
    pick = first_edge(edges); // R13
    if (n_edges == 3'h2) begin
      // follow the side of the last error, else the frequency direction
      if (phase_error > 4'sh0) begin
        pick = last_edge(edges); // R14
      end else if (phase_error < 4'sh0) begin
        pick = first_edge(edges); // R14
      end else if (freq_fast) begin
        pick = first_edge(edges); // R14
      end else begin
        pick = last_edge(edges); // R14
      end
    end
    next_multi = samp_new && (n_edges > 3'h1); // R12
    next_err_update = samp_new && locked &&
                      (n_edges == 3'h1 || n_edges == 3'h2); // R11 R16
    next_phase_error = phase_error;
    if (next_err_update) begin
      next_phase_error = signed'({1'b0, pick} - cdr_pkg::CENTER_EDGE); // R9 R19
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_error <= cdr_pkg::ERR_RST;
      err_update <= 1'b0;
      multi_trans <= 1'b0;
    end else begin
      phase_error <= next_phase_error; // R11
      err_update <= next_err_update;
      multi_trans <= next_multi;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_reset_idle_out: assert property ($rose(reset_n) |-> !osc_behind && !osc_ahead) // R1
    else $error("detector not idle after reset");
  a_ref_raises_up: assert property ( // R2
    (pfd_state == cdr_pkg::PFD_IDLE && ref_rise && !osc_rise) |=> osc_behind && !osc_ahead)
    else $error("reference edge did not raise osc_behind");
  a_both_then_clear: assert property ((pfd_state == cdr_pkg::PFD_BEHIND && osc_rise) // R3
    |=> (osc_behind && osc_ahead) ##1 (!osc_behind && !osc_ahead))
    else $error("both-high clear sequence wrong");
  a_clear_one_cycle: assert property ((osc_behind && osc_ahead) // R21
    |=> pfd_state == cdr_pkg::PFD_IDLE)
    else $error("clear state lasted more than one cycle");
  a_level_no_effect: assert property ((pfd_state == cdr_pkg::PFD_BEHIND && !osc_rise) // R4
    |=> osc_behind && !osc_ahead)
    else $error("lag state left without an oscillator edge");
  a_osc_first_ahead: assert property ( // R5
    (pfd_state == cdr_pkg::PFD_IDLE && osc_rise && !ref_rise) |=> osc_ahead && !osc_behind)
    else $error("leading oscillator not flagged ahead");
  a_error_hold: assert property ($changed(phase_error) |-> err_update) // R11
    else $error("phase error moved without update");
  a_update_locked: assert property (err_update |-> $past(locked)) // R16
    else $error("phase error updated before lock");
  a_multi_flag: assert property ((samp_new && n_edges > 3'h1) |=> multi_trans) // R12
    else $error("multiple transitions not flagged");
  a_excess_ignored: assert property ((samp_new && n_edges > 3'h2) |=> !err_update) // R13
    else $error("update taken with too many transitions");
  a_retime_center: assert property (osc_fall // R20
    |=> retimed_data == $past(chain[cdr_pkg::CENTER_TAP]))
    else $error("retimed bit not from centre tap");
  a_two_stage_sample: assert property (osc_rise |=> samp2 == $past(samp1)) // R8
    else $error("second sample stage skipped");

  c_lock_reached: cover property ($rose(locked));
  c_two_transitions: cover property (samp_new && locked && n_edges == 3'h2);
  c_clear_cycle: cover property (pfd_state == cdr_pkg::PFD_CLEAR);
  c_centered: cover property (err_update && phase_error == 4'sh0);

endmodule

//--- verification/cdr_source_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// far side: reference, controlled oscillator and coded data source
// ----------------------------------------------------------------------------
module cdr_source_model (
  // clock
  input wire logic core_clk,
  // control from the bench
  input wire logic run,
  input wire logic ref_on,
  input wire logic [2:0] lag,
  input wire logic [7:0] mask,
  input wire logic ref_man,
  input wire logic osc_man,
  // towards the detector
  output logic ref_osc_in,
  output logic controlled_osc_clock,
  output logic serial_in
);
  logic [2:0] phase;
  logic [2:0] osc_ph;

  // quiet start so the detector sees no edge at reset release
  initial begin
    phase = 3'h0;
    ref_osc_in = 1'h0;
    controlled_osc_clock = 1'h0;
    serial_in = 1'h0;
  end

  // oscillator trails the reference by lag cycles
  assign osc_ph = phase - lag;

  // eight cycle period, half duty; manual levels when not running
  always @(posedge core_clk) begin
    phase <= phase + 3'h1;
    ref_osc_in <= run ? (ref_on & ~phase[2]) : ref_man;
    controlled_osc_clock <= run ? ~osc_ph[2] : osc_man;
    // pattern repeats each period, one level change per bit time
    if (mask[phase]) begin
      serial_in <= ~serial_in;
    end
  end
endmodule

//--- verification/cdr_phase_detector_bench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// self-checking bench for the phase detection core
// ----------------------------------------------------------------------------
module cdr_phase_detector_bench;
  logic core_clk, reset_n, run, ref_on, ref_man, osc_man;
  logic [2:0] lag;
  logic [7:0] mask;
  logic ref_osc_in, controlled_osc_clock, serial_in;
  logic osc_behind, osc_ahead, locked, err_update, multi_trans, retimed_data;
  logic signed [cdr_pkg::ERR_W-1:0] phase_error, pe_seen, pe_prev, pe_exp, pe_hold;
  logic upd_seen, prev_valid, rd;
  int error_cnt, checks, n_upd, n_multi;

  cdr_source_model partner (
    .core_clk(core_clk), .run(run), .ref_on(ref_on), .lag(lag), .mask(mask),
    .ref_man(ref_man), .osc_man(osc_man), .ref_osc_in(ref_osc_in),
    .controlled_osc_clock(controlled_osc_clock), .serial_in(serial_in)
  );

  cdr_phase_detector dut (
    .core_clk(core_clk), .reset_n(reset_n), .ref_osc_in(ref_osc_in),
    .controlled_osc_clock(controlled_osc_clock), .serial_in(serial_in),
    .osc_behind(osc_behind), .osc_ahead(osc_ahead), .locked(locked),
    .phase_error(phase_error), .err_update(err_update),
    .multi_trans(multi_trans), .retimed_data(retimed_data)
  );

  // 125 MHz core clock
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic pfd_is(input int n, input logic b, input logic a);
    repeat (n) @(posedge core_clk);
    #1;
    check(8'(osc_behind), 8'(b), "osc_behind");
    check(8'(osc_ahead), 8'(a), "osc_ahead");
  endtask

  // eight rotations of a data pattern; counts pulses in one settled period each
  task automatic sweep(input logic [7:0] pat, input logic steps);
    n_upd = 0;
    n_multi = 0;
    prev_valid = 1'h0;
    for (int r = 0; r < 8; r++) begin
      @(posedge core_clk) mask <= (pat << r) | (pat >> (8 - r));
      upd_seen = 1'h0;
      // three oscillator periods of sampling latency before results are clean
      repeat (24) @(posedge core_clk);
      repeat (8) begin
        @(posedge core_clk);
        #1;
        if (err_update === 1'h1) begin
          upd_seen = 1'h1;
          pe_seen = phase_error;
          n_upd++;
        end
        if (multi_trans === 1'h1) n_multi++;
      end
      // a toggle one cycle later is one tap younger, one step nearer tap zero
      if (steps && upd_seen && prev_valid) begin
        pe_exp = pe_prev - 4'sh1;
        check(8'(pe_seen), 8'(pe_exp), "error step");
      end
      prev_valid = upd_seen;
      pe_prev = pe_seen;
    end
  endtask

  task automatic t_reset();
    @(posedge core_clk);
    #1;
    check(8'({osc_behind, osc_ahead, locked, err_update, multi_trans}), 8'h00, "reset");
    check(8'(phase_error), 8'h00, "reset error");
    $display("test reset done");
  endtask

  task automatic t_pfd();
    @(posedge core_clk) ref_man <= 1'h1;
    pfd_is(2, 1'h1, 1'h0);
    @(posedge core_clk) ref_man <= 1'h0;
    pfd_is(2, 1'h1, 1'h0);
    @(posedge core_clk) osc_man <= 1'h1;
    pfd_is(2, 1'h1, 1'h1);
    pfd_is(1, 1'h0, 1'h0);
    @(posedge core_clk) osc_man <= 1'h0;
    @(posedge core_clk) osc_man <= 1'h1;
    pfd_is(2, 1'h0, 1'h1);
    @(posedge core_clk) ref_man <= 1'h1;
    pfd_is(2, 1'h1, 1'h1);
    pfd_is(1, 1'h0, 1'h0);
    $display("test pfd done");
  endtask

  task automatic t_lock();
    // oscillator alone: no comparisons, so data must not steer yet
    @(posedge core_clk) run <= 1'h1;
    sweep(8'h01, 1'h0);
    check(8'(n_upd), 8'h00, "updates unlocked");
    check(8'(locked), 8'h00, "locked early");
    @(posedge core_clk) ref_on <= 1'h1;
    repeat (96) @(posedge core_clk);
    #1;
    check(8'(locked), 8'h00, "locked before count");
    for (int i = 0; i < 200 && locked !== 1'h1; i++) @(posedge core_clk);
    #1;
    check(8'(locked), 8'h01, "locked");
    $display("test lock done");
  endtask

  task automatic t_data();
    sweep(8'h01, 1'h1);
    check(8'(n_upd), 8'h07, "single updates");
    check(8'(n_multi), 8'h00, "single multi");
    @(posedge core_clk);
    #1;
    rd = retimed_data;
    repeat (8) @(posedge core_clk);
    #1;
    check(8'(retimed_data), 8'(!rd), "retimed");
    sweep(8'h11, 1'h0);
    check(8'(n_upd), 8'h08, "pair updates");
    check(8'(n_multi), 8'h06, "pair multi");
    sweep(8'h55, 1'h0);
    check(8'(n_upd), 8'h00, "crowded updates");
    check(8'(n_multi), 8'h08, "crowded multi");
    // let the crowded tail drain first, it may still yield one last update
    @(posedge core_clk) mask <= 8'h00;
    repeat (32) @(posedge core_clk);
    #1;
    pe_hold = phase_error;
    sweep(8'h00, 1'h0);
    check(8'(n_upd), 8'h00, "quiet updates");
    check(8'(phase_error), 8'(pe_hold), "held error");
    $display("test data done");
  endtask

  task automatic t_loose();
    // a free-running pair always relocks; manual edges ten cycles apart
    // give a single-output pulse well past the tight window
    @(posedge core_clk) begin
      run <= 1'h0;
      ref_man <= 1'h0;
      osc_man <= 1'h0;
    end
    // two rounds, so a detector left ahead still meets one loose comparison
    repeat (2) begin
      repeat (3) @(posedge core_clk);
      ref_man <= 1'h1;
      repeat (10) @(posedge core_clk);
      osc_man <= 1'h1;
      repeat (10) @(posedge core_clk);
      ref_man <= 1'h0;
      osc_man <= 1'h0;
    end
    for (int i = 0; i < 64 && locked !== 1'h0; i++) @(posedge core_clk);
    #1;
    check(8'(locked), 8'h00, "lock lost");
    $display("test loose done");
  endtask

  // watchdog well past the expected run of about two thousand cycles
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    error_cnt = 0;
    checks = 0;
    reset_n = 1'h0;
    run = 1'h0;
    ref_on = 1'h0;
    ref_man = 1'h0;
    osc_man = 1'h0;
    lag = 3'h2;
    mask = 8'h00;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'h1;
    t_reset();
    t_pfd();
    t_lock();
    t_data();
    t_loose();
    tally_and_finish();
  end
endmodule
